// file: src/dsq_sequencer.sv
// Decided for this implementation: the AHB-Lite register port and the register addresses.
`include "dsq_cfg.svh"

module dsq_sequencer #(
  parameter logic [31:0] CONTACTOR_WAIT_CYCLES = 32'(`DSQ_CONTACTOR_WAIT_CYC),
  parameter logic [31:0] FSTOP_TIME_CYCLES     = 32'(`DSQ_FSTOP_TIME_CYC),
  parameter logic [31:0] STOP_DELAY_CYCLES     = 32'(`DSQ_STOP_DELAY_CYC)
) (
  input  wire logic        core_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic [31:0]      hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic        run_in,
  input  wire logic        jog_in,
  input  wire logic        enable_in,
  input  wire logic        not_coast_stop_in,
  input  wire logic        not_fast_stop_in,
  input  wire logic        trip_reset_in,
  input  wire logic        trip_in,
  input  wire logic        contactor_closed_in,
  input  wire logic        defluxed_in,
  input  wire logic        stack_quenched_in,
  input  wire logic        zero_setpoint_in,
  input  wire logic        cfg_restore_in,
  output logic [2:0]       main_phase_code_out,
  output logic             tripped_out,
  output logic             running_out,
  output logic             jogging_out,
  output logic             stopping_out,
  output logic             contactor_out,
  output logic             switch_on_enable_out,
  output logic             switched_on_out,
  output logic             ready_out,
  output logic             healthy_out,
  output logic             irq_out
);
  dsq_pkg::dsq_state_type state;
  dsq_pkg::dsq_state_type next_state;
  logic [`DSQ_CTRL_WIDTH-1:0] ctrl;
  logic [`DSQ_CTRL_WIDTH-1:0] next_ctrl;
  logic [`DSQ_IRQ_WIDTH-1:0]  irq_stat;
  logic [`DSQ_IRQ_WIDTH-1:0]  next_irq_stat;
  logic [`DSQ_IRQ_WIDTH-1:0]  irq_mask;
  logic [`DSQ_IRQ_WIDTH-1:0]  next_irq_mask;
  logic [`DSQ_IRQ_WIDTH-1:0]  events;
  logic        wr_pend, next_wr_pend, rd_pend, next_rd_pend;
  logic        mapped, next_mapped;
  logic [7:0]  addr_q, next_addr_q;
  logic [31:0] next_hrdata, rd_mux;
  logic        next_hreadyout, next_irq;
  logic        take, wr_now;
  logic        run_cmd, jog_cmd, en_cmd, ncoast, nfast, trst_cmd, trst_prev;
  logic        cfg_prev, cfg_leave, halts_ok, trip_any;
  logic        cont_tmo, fstop_done, stop_done, stop_cycle;
  logic        jog_cycle, next_jog_cycle, heal_hold, next_heal_hold;
  logic        next_contactor;
  logic [2:0]  next_code;
  logic        next_trip_o, next_run_o, next_jog_o, next_stop_o;
  logic        next_soe_o, next_swon_o, next_rdy_o, next_heal_o;

  // bus address phase acceptance and data-phase write strobe
  assign take   = hsel_in && htrans_in[1] && hready_in;
  assign wr_now = wr_pend && hready_in && mapped;

  // command source: register when remote, halts always ANDed with pins
  assign run_cmd   = ctrl[`DSQ_CTRL_REMOTE] ? ctrl[`DSQ_CTRL_RUN] : run_in;
  assign jog_cmd   = ctrl[`DSQ_CTRL_REMOTE] ? ctrl[`DSQ_CTRL_JOG] : jog_in;
  assign en_cmd    = enable_in && (!ctrl[`DSQ_CTRL_REMOTE] || ctrl[`DSQ_CTRL_ENABLE]);
  assign ncoast    = not_coast_stop_in && (!ctrl[`DSQ_CTRL_REMOTE] || ctrl[`DSQ_CTRL_NOT_COAST]);
  assign nfast     = not_fast_stop_in && (!ctrl[`DSQ_CTRL_REMOTE] || ctrl[`DSQ_CTRL_NOT_FAST]);
  assign trst_cmd  = ctrl[`DSQ_CTRL_REMOTE] ? ctrl[`DSQ_CTRL_TRIP_RESET] : trip_reset_in;
  assign halts_ok  = ncoast && nfast;
  assign cfg_leave = cfg_prev && !ctrl[`DSQ_CTRL_CFG_MODE];
  assign stop_cycle = !run_cmd && !jog_cmd;

  // trip causes include contactor loss once the contactor is expected
  always_comb begin
    trip_any = trip_in;
    if (state == dsq_pkg::ST_SWITCHED_ON && cont_tmo)
      trip_any = 1'b1;
    if ((state == dsq_pkg::ST_READY || state == dsq_pkg::ST_ENABLED ||
         state == dsq_pkg::ST_FSTOP_ACTIVE) && !contactor_closed_in)
      trip_any = 1'b1;
  end

  // contactor wait, quick-halt and stop-delay timers
  dsq_timer u_cont_timer (
    .core_clk_in (core_clk_in),
    .reset_n_in  (reset_n_in),
    .run_in      (state == dsq_pkg::ST_SWITCHED_ON && !contactor_closed_in),
    .limit_in    (CONTACTOR_WAIT_CYCLES),
    .done_out    (cont_tmo)
  );
  dsq_timer u_fstop_timer (
    .core_clk_in (core_clk_in),
    .reset_n_in  (reset_n_in),
    .run_in      (state == dsq_pkg::ST_FSTOP_ACTIVE),
    .limit_in    (FSTOP_TIME_CYCLES),
    .done_out    (fstop_done)
  );
  dsq_timer u_stop_timer (
    .core_clk_in (core_clk_in),
    .reset_n_in  (reset_n_in),
    .run_in      (state == dsq_pkg::ST_ENABLED && stop_cycle),
    .limit_in    (STOP_DELAY_CYCLES),
    .done_out    (stop_done)
  );

  // next state, exits checked in priority order
  always_comb begin
    next_state = state;
    if (cfg_restore_in || ctrl[`DSQ_CTRL_CFG_MODE] || cfg_leave) begin
      next_state = dsq_pkg::ST_START_DISABLED;
    end else begin
      unique case (state)
        dsq_pkg::ST_START_DISABLED: begin
          if (trip_any) next_state = dsq_pkg::ST_TRIP_ACTIVE;
          else if (stop_cycle && halts_ok) next_state = dsq_pkg::ST_START_ENABLED;
        end
        dsq_pkg::ST_START_ENABLED: begin
          if (trip_any) next_state = dsq_pkg::ST_TRIP_ACTIVE;
          else if (!halts_ok) next_state = dsq_pkg::ST_START_DISABLED;
          else if (run_cmd || jog_cmd) next_state = dsq_pkg::ST_SWITCHED_ON;
        end
        dsq_pkg::ST_SWITCHED_ON: begin
          if (trip_any) next_state = dsq_pkg::ST_TRIP_ACTIVE;
          else if (!halts_ok) next_state = dsq_pkg::ST_START_DISABLED;
          else if (stop_cycle) next_state = dsq_pkg::ST_START_ENABLED;
          else if (contactor_closed_in && defluxed_in) next_state = dsq_pkg::ST_READY;
        end
        dsq_pkg::ST_READY: begin
          if (trip_any) next_state = dsq_pkg::ST_TRIP_ACTIVE;
          else if (!halts_ok) next_state = dsq_pkg::ST_START_DISABLED;
          else if (stop_cycle) next_state = dsq_pkg::ST_START_ENABLED;
          else if (en_cmd) next_state = dsq_pkg::ST_ENABLED;
        end
        dsq_pkg::ST_ENABLED: begin
          if (trip_any) next_state = dsq_pkg::ST_TRIP_ACTIVE;
          else if (!ncoast) next_state = dsq_pkg::ST_START_DISABLED;
          else if (!nfast) next_state = dsq_pkg::ST_FSTOP_ACTIVE;
          else if (stop_cycle && stop_done) next_state = dsq_pkg::ST_START_ENABLED;
          else if (!en_cmd) next_state = dsq_pkg::ST_READY;
        end
        dsq_pkg::ST_FSTOP_ACTIVE: begin
          if (trip_any) next_state = dsq_pkg::ST_TRIP_ACTIVE;
          else if (fstop_done || ctrl[`DSQ_CTRL_FSTOP_COAST] || zero_setpoint_in)
            next_state = dsq_pkg::ST_START_DISABLED;
        end
        dsq_pkg::ST_TRIP_ACTIVE: begin
          if (stack_quenched_in) next_state = dsq_pkg::ST_TRIPPED;
        end
        dsq_pkg::ST_TRIPPED: begin
          if (!trip_in && trst_cmd && !trst_prev) next_state = dsq_pkg::ST_START_DISABLED;
        end
      endcase
    end
  end

  // jog cycle, healthy recovery and contactor hold
  always_comb begin
    next_jog_cycle = 1'b0;
    if (state == dsq_pkg::ST_ENABLED && !run_cmd) begin
      if (jog_cmd) next_jog_cycle = 1'b1;
      else if (!stop_done) next_jog_cycle = jog_cycle;
    end
    next_heal_hold = (state == dsq_pkg::ST_TRIPPED) && (heal_hold || stop_cycle);
    unique case (state)
      dsq_pkg::ST_START_DISABLED, dsq_pkg::ST_START_ENABLED: next_contactor = contactor_out;
      dsq_pkg::ST_TRIPPED: next_contactor = 1'b0;
      default: next_contactor = 1'b1;
    endcase
  end

  // status outputs decoded from the registered state and, for stopping, the run and jog commands
  always_comb begin
    next_code   = state;
    next_trip_o = state == dsq_pkg::ST_TRIP_ACTIVE || state == dsq_pkg::ST_TRIPPED;
    next_run_o  = state == dsq_pkg::ST_ENABLED;
    next_jog_o  = state == dsq_pkg::ST_ENABLED && jog_cycle;
    next_stop_o = (state == dsq_pkg::ST_ENABLED && stop_cycle && !stop_done) ||
                  state == dsq_pkg::ST_FSTOP_ACTIVE;
    next_soe_o  = state != dsq_pkg::ST_START_DISABLED && state != dsq_pkg::ST_TRIPPED;
    next_swon_o = state >= dsq_pkg::ST_SWITCHED_ON && state != dsq_pkg::ST_TRIPPED;
    next_rdy_o  = state >= dsq_pkg::ST_READY && state != dsq_pkg::ST_TRIPPED;
    next_heal_o = state <= dsq_pkg::ST_FSTOP_ACTIVE ||
                  (state == dsq_pkg::ST_TRIPPED && heal_hold);
  end

  // bus slave, control, mask and sticky status next values
  always_comb begin
    next_wr_pend   = take && hwrite_in;
    next_rd_pend   = take && !hwrite_in;
    next_addr_q    = take ? haddr_in[7:0] : addr_q;
    next_mapped    = take ? (haddr_in[31:8] == 24'h00_0000) : mapped;
    next_hreadyout = rd_pend ? 1'b1 : (take && !hwrite_in) ? 1'b0 : hreadyout_out;
    unique case (addr_q)
      `DSQ_OFF_CTRL:     rd_mux = 32'(ctrl);
      `DSQ_OFF_STATUS:   rd_mux = {20'h0_0000, healthy_out, ready_out, switched_on_out,
                                   switch_on_enable_out, contactor_out, stopping_out,
                                   jogging_out, running_out, tripped_out, main_phase_code_out};
      `DSQ_OFF_IRQ_STAT: rd_mux = 32'(irq_stat);
      `DSQ_OFF_IRQ_MASK: rd_mux = 32'(irq_mask);
      default:           rd_mux = 32'h0000_0000;
    endcase
    if (!mapped) rd_mux = 32'h0000_0000;
    next_hrdata = rd_pend ? rd_mux : hrdata_out;
    next_ctrl     = (wr_now && addr_q == `DSQ_OFF_CTRL) ? hwdata_in[`DSQ_CTRL_WIDTH-1:0] : ctrl;
    next_irq_mask = (wr_now && addr_q == `DSQ_OFF_IRQ_MASK) ? hwdata_in[`DSQ_IRQ_WIDTH-1:0] : irq_mask;
    events[`DSQ_IRQ_STATE_CHG]    = next_state != state;
    events[`DSQ_IRQ_TRIP]         = next_state == dsq_pkg::ST_TRIP_ACTIVE && state != dsq_pkg::ST_TRIP_ACTIVE;
    events[`DSQ_IRQ_CONT_TIMEOUT] = state == dsq_pkg::ST_SWITCHED_ON && cont_tmo;
    next_irq_stat = irq_stat;
    if (wr_now && addr_q == `DSQ_OFF_IRQ_STAT)
      next_irq_stat = irq_stat & ~hwdata_in[`DSQ_IRQ_WIDTH-1:0];
    next_irq_stat = next_irq_stat | events;                           // set beats clear
    next_irq      = |(next_irq_stat & next_irq_mask);
  end

  // register everything
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      state         <= dsq_pkg::ST_START_DISABLED;
      contactor_out <= 1'b0;
      ctrl          <= `DSQ_CTRL_RESET;
      irq_stat      <= `DSQ_IRQ_RESET;
      irq_mask      <= `DSQ_IRQ_RESET;
      wr_pend       <= 1'b0;
      rd_pend       <= 1'b0;
      mapped        <= 1'b0;
      addr_q        <= 8'h00;
      hrdata_out    <= 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      irq_out       <= 1'b0;
      trst_prev     <= 1'b0;
      cfg_prev      <= 1'b0;
      jog_cycle     <= 1'b0;
      heal_hold     <= 1'b0;
      main_phase_code_out  <= 3'h0;
      tripped_out          <= 1'b0;
      running_out          <= 1'b0;
      jogging_out          <= 1'b0;
      stopping_out         <= 1'b0;
      switch_on_enable_out <= 1'b0;
      switched_on_out      <= 1'b0;
      ready_out            <= 1'b0;
      healthy_out          <= 1'b0;
    end else begin
      state         <= next_state;
      contactor_out <= next_contactor;
      ctrl          <= next_ctrl;
      irq_stat      <= next_irq_stat;
      irq_mask      <= next_irq_mask;
      wr_pend       <= next_wr_pend;
      rd_pend       <= next_rd_pend;
      mapped        <= next_mapped;
      addr_q        <= next_addr_q;
      hrdata_out    <= next_hrdata;
      hreadyout_out <= next_hreadyout;
      hresp_out     <= 1'b0;
      irq_out       <= next_irq;
      trst_prev     <= trst_cmd;
      cfg_prev      <= ctrl[`DSQ_CTRL_CFG_MODE];
      jog_cycle     <= next_jog_cycle;
      heal_hold     <= next_heal_hold;
      main_phase_code_out  <= next_code;
      tripped_out          <= next_trip_o;
      running_out          <= next_run_o;
      jogging_out          <= next_jog_o;
      stopping_out         <= next_stop_o;
      switch_on_enable_out <= next_soe_o;
      switched_on_out      <= next_swon_o;
      ready_out            <= next_rdy_o;
      healthy_out          <= next_heal_o;
    end
  end

  // checks on the sequencing behaviour
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);

  property p_code; 1 |=> main_phase_code_out == 3'($past(state)); endproperty
  a_code: assert property (p_code) else $error("phase code not the previous state");
  property p_dis_out;
    state == dsq_pkg::ST_START_DISABLED |=> !switch_on_enable_out && !switched_on_out &&
      !ready_out && !tripped_out && !running_out && !stopping_out;
  endproperty
  a_dis_out: assert property (p_dis_out) else $error("outputs wrong in start disabled");
  property p_swon;
    state == dsq_pkg::ST_START_ENABLED && !trip_any && halts_ok && run_cmd && !cfg_restore_in &&
      !ctrl[`DSQ_CTRL_CFG_MODE] && !cfg_leave |=> state == dsq_pkg::ST_SWITCHED_ON;
  endproperty
  a_swon: assert property (p_swon) else $error("switch-on not accepted");
  property p_rdy; 1 |=> ready_out == ($past(state) inside {[3:6]}); endproperty
  a_rdy: assert property (p_rdy) else $error("ready output wrong");
  property p_run; running_out |-> $past(state) == dsq_pkg::ST_ENABLED; endproperty
  a_run: assert property (p_run) else $error("running outside enabled");
  property p_tripact;
    state == dsq_pkg::ST_TRIP_ACTIVE |=> tripped_out && !healthy_out && ready_out && contactor_out;
  endproperty
  a_tripact: assert property (p_tripact) else $error("trip active outputs wrong");
  property p_tripped;
    state == dsq_pkg::ST_TRIPPED |=> tripped_out && !contactor_out && !switched_on_out && !running_out;
  endproperty
  a_tripped: assert property (p_tripped) else $error("tripped outputs wrong");
  property p_cont_hold;
    state inside {[0:1]} && $past(state) inside {[0:1]} |=> $stable(contactor_out);
  endproperty
  a_cont_hold: assert property (p_cont_hold) else $error("contactor not held");
  property p_fstop; state == dsq_pkg::ST_FSTOP_ACTIVE |=> stopping_out; endproperty
  a_fstop: assert property (p_fstop) else $error("stopping low in quick halt");
  property p_prio; state == dsq_pkg::ST_START_DISABLED && trip_in && !cfg_restore_in &&
      !ctrl[`DSQ_CTRL_CFG_MODE] && !cfg_leave |=> state == dsq_pkg::ST_TRIP_ACTIVE;
  endproperty
  a_prio: assert property (p_prio) else $error("trip did not take priority");
  property p_restore; cfg_restore_in |=> state == dsq_pkg::ST_START_DISABLED; endproperty
  a_restore: assert property (p_restore) else $error("restore did not disable");
  property p_clear;
    state == dsq_pkg::ST_START_DISABLED && $past(state) == dsq_pkg::ST_TRIPPED |->
      $past(trst_cmd && !trst_prev && !trip_in) || $past(cfg_restore_in || ctrl[`DSQ_CTRL_CFG_MODE] || cfg_leave);
  endproperty
  a_clear: assert property (p_clear) else $error("left tripped without fault clear");
  property p_reset; @(posedge core_clk_in) disable iff (1'b0)
    !reset_n_in |=> state == dsq_pkg::ST_START_DISABLED && !contactor_out;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");

  c_enabled: cover property (state == dsq_pkg::ST_ENABLED);
  c_tripped: cover property (state == dsq_pkg::ST_TRIPPED ##1 state == dsq_pkg::ST_START_DISABLED);
  c_fstop:   cover property (state == dsq_pkg::ST_FSTOP_ACTIVE ##1 state == dsq_pkg::ST_START_DISABLED);
  c_jog:     cover property (jogging_out);
endmodule

// file: src/dsq_cfg.svh
`ifndef DSQ_CFG_SVH
`define DSQ_CFG_SVH

// register byte offsets
`define DSQ_OFF_CTRL          8'h00
`define DSQ_OFF_STATUS        8'h04
`define DSQ_OFF_IRQ_STAT      8'h08
`define DSQ_OFF_IRQ_MASK      8'h0C

// control register fields
`define DSQ_CTRL_RUN          0
`define DSQ_CTRL_JOG          1
`define DSQ_CTRL_ENABLE       2
`define DSQ_CTRL_NOT_COAST    3
`define DSQ_CTRL_NOT_FAST     4
`define DSQ_CTRL_TRIP_RESET   5
`define DSQ_CTRL_REMOTE       6
`define DSQ_CTRL_CFG_MODE     7
`define DSQ_CTRL_FSTOP_COAST  8
`define DSQ_CTRL_WIDTH        9
`define DSQ_CTRL_RESET        9'h018

// status register fields
`define DSQ_ST_CODE_LSB       0
`define DSQ_ST_TRIPPED        3
`define DSQ_ST_RUNNING        4
`define DSQ_ST_JOGGING        5
`define DSQ_ST_STOPPING       6
`define DSQ_ST_CONTACTOR      7
`define DSQ_ST_SW_ON_EN       8
`define DSQ_ST_SWITCHED_ON    9
`define DSQ_ST_READY          10
`define DSQ_ST_HEALTHY        11

// interrupt bits
`define DSQ_IRQ_STATE_CHG     0
`define DSQ_IRQ_TRIP          1
`define DSQ_IRQ_CONT_TIMEOUT  2
`define DSQ_IRQ_WIDTH         3
`define DSQ_IRQ_RESET         3'h0

// timing
`define DSQ_CLK_MHZ           100
`define DSQ_CONTACTOR_WAIT_S  10
`define DSQ_FSTOP_TIME_MS     1000
`define DSQ_STOP_DELAY_MS     500
`define DSQ_CONTACTOR_WAIT_CYC (`DSQ_CONTACTOR_WAIT_S * `DSQ_CLK_MHZ * 1000000)
`define DSQ_FSTOP_TIME_CYC    (`DSQ_FSTOP_TIME_MS * `DSQ_CLK_MHZ * 1000)
`define DSQ_STOP_DELAY_CYC    (`DSQ_STOP_DELAY_MS * `DSQ_CLK_MHZ * 1000)

`endif

// file: src/dsq_pkg.sv
package dsq_pkg;
  // main sequencing phases, in code order 0..7
  typedef enum logic [2:0] {
    ST_START_DISABLED,
    ST_START_ENABLED,
    ST_SWITCHED_ON,
    ST_READY,
    ST_ENABLED,
    ST_FSTOP_ACTIVE,
    ST_TRIP_ACTIVE,
    ST_TRIPPED
  } dsq_state_type;
endpackage

// file: src/dsq_timer.sv
module dsq_timer (
  input  wire logic        core_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        run_in,
  input  wire logic [31:0] limit_in,
  output logic             done_out
);
  logic [31:0] count;
  logic [31:0] next_count;
  logic        next_done;

  // counts while run is high, restarts whenever run drops
  always_comb begin
    next_count = count;
    next_done  = done_out;
    if (!run_in) begin
      next_count = 32'h0000_0000;
      next_done  = 1'b0;
    end else if (count >= limit_in) begin
      next_done = 1'b1;
    end else begin
      next_count = count + 32'h0000_0001;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      count    <= 32'h0000_0000;
      done_out <= 1'b0;
    end else begin
      count    <= next_count;
      done_out <= next_done;
    end
  end
endmodule

// file: test/dsq_field.sv
// far side of the drive: output contactor and power stack feedback
module dsq_field #(
  parameter int QUENCH_DELAY = 40
) (
  input  wire logic core_clk_in,
  input  wire logic contactor_cmd_in,
  input  wire logic tripped_in,
  output logic      closed_out,
  output logic      defluxed_out,
  output logic      quenched_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0]  cont_q = 3'h0;
  int unsigned trip_cnt = 0;

  // contactor lags its coil; stack quench takes a while after a trip
  always @(posedge core_clk_in) begin
    cont_q   <= {cont_q[1:0], contactor_cmd_in};
    trip_cnt <= tripped_in ? trip_cnt + 1 : 0;
  end

  // feedback levels seen by the drive
  assign closed_out   = cont_q[2];
  assign defluxed_out = 1'b1;
  assign quenched_out = (trip_cnt >= QUENCH_DELAY);
endmodule

// file: test/drive_sequencing_state_machine_bench.sv
`include "dsq_cfg.svh"
module drive_sequencing_state_machine_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        core_clk_in = 1'b0;
  logic        reset_n_in  = 1'b0;
  logic        hsel = 1'b0, hwrite = 1'b0, hready, irq, contactor, tripped, hresp;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rdata;
  logic        run = 1'b0, jog = 1'b0, enable = 1'b0, not_coast = 1'b1, not_fast = 1'b1;
  logic        trip = 1'b0, trip_reset = 1'b0, cfg_restore = 1'b0, closed, defluxed, quenched;
  logic [2:0]  code;
  int          fails = 0;
  int          total_checks = 0;

  // 100 MHz clock
  always #5 core_clk_in = ~core_clk_in;

  dsq_sequencer #(.CONTACTOR_WAIT_CYCLES(32'h0000_0014), .FSTOP_TIME_CYCLES(32'h0000_0014),
    .STOP_DELAY_CYCLES(32'h0000_000A))
    dsq_sequencer_inst (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .run_in(run),
    .jog_in(jog), .enable_in(enable), .not_coast_stop_in(not_coast), .not_fast_stop_in(not_fast),
    .trip_reset_in(trip_reset), .trip_in(trip), .contactor_closed_in(closed), .defluxed_in(defluxed),
    .stack_quenched_in(quenched), .zero_setpoint_in(1'b0), .cfg_restore_in(cfg_restore),
    .main_phase_code_out(code), .tripped_out(tripped), .running_out(), .jogging_out(),
    .stopping_out(), .contactor_out(contactor), .switch_on_enable_out(), .switched_on_out(),
    .ready_out(), .healthy_out(), .irq_out(irq));

  dsq_field dsq_field_inst (.core_clk_in(core_clk_in), .contactor_cmd_in(contactor), .tripped_in(tripped),
    .closed_out(closed), .defluxed_out(defluxed), .quenched_out(quenched));

  // verdict and end of run
  task automatic end_of_test;
    if (fails == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // compare seen against expected
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // falling-edge sample equals what the next rising edge sees
  task automatic wait_ready;
    int n;
    logic ok;
    n = 0;
    ok = 1'b0;
    while (!ok) begin
      @(negedge core_clk_in);
      ok = (hready === 1'b1);
      rdata = hrdata;
      @(posedge core_clk_in);
      n++;
      if (n > 50) begin
        fails++;
        end_of_test();
      end
    end
  endtask

  // one single word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= 32'(a);
    htrans <= 2'b10;
    hwrite <= wr;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
  endtask

  // wait for a phase code, then read and compare the status word
  task automatic status(input logic [2:0] c, input logic [31:0] exp);
    int n;
    n = 0;
    do begin
      @(negedge core_clk_in);
      n++;
    end while (code !== c && n < 300);
    check("phase code", {29'h0, code}, {29'h0, c});
    // a phase that never comes ends the run here
    if (code !== c) end_of_test();
    @(posedge core_clk_in);
    bus(1'b0, `DSQ_OFF_STATUS, 32'h0000_0000);
    check("status", rdata, exp);
    check("response", {31'h0, hresp}, 32'h0000_0000);
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge core_clk_in);
    reset_n_in <= 1'b1;
    @(posedge core_clk_in);
    @(negedge core_clk_in);
    check("code after reset", {29'h0, code}, 32'h0000_0000);
    check("contactor after reset", {31'h0, contactor}, 32'h0000_0000);
    @(posedge core_clk_in);
    bus(1'b1, `DSQ_OFF_IRQ_MASK, 32'h0000_0001);
    bus(1'b0, `DSQ_OFF_CTRL, 32'h0000_0000);
    check("ctrl reset", rdata, 32'h0000_0018);
    bus(1'b0, 8'h10, 32'h0000_0000);
    check("unmapped", rdata, 32'h0000_0000);
    status(3'd1, 32'h0000_0901);
    run <= 1'b1;
    status(3'd3, 32'h0000_0F83);
    enable <= 1'b1;
    status(3'd4, 32'h0000_0F94);
    not_fast <= 1'b0;
    status(3'd5, 32'h0000_0FC5);
    status(3'd0, 32'h0000_0880);
    not_fast <= 1'b1;
    run <= 1'b0;
    status(3'd1, 32'h0000_0981);
    run <= 1'b1;
    status(3'd4, 32'h0000_0F94);
    trip <= 1'b1;
    status(3'd6, 32'h0000_078E);
    status(3'd7, 32'h0000_000F);
    run <= 1'b0;
    enable <= 1'b0;
    status(3'd7, 32'h0000_080F);
    trip <= 1'b0;
    @(posedge core_clk_in);
    trip_reset <= 1'b1;
    status(3'd1, 32'h0000_0901);
    @(negedge core_clk_in);
    check("irq raised", {31'h0, irq}, 32'h0000_0001);
    @(posedge core_clk_in);
    bus(1'b0, `DSQ_OFF_IRQ_STAT, 32'h0000_0000);
    check("irq status", rdata, 32'h0000_0003);
    bus(1'b1, `DSQ_OFF_IRQ_STAT, 32'h0000_0003);
    bus(1'b0, `DSQ_OFF_IRQ_STAT, 32'h0000_0000);
    check("irq cleared", rdata, 32'h0000_0000);
    check("irq low", {31'h0, irq}, 32'h0000_0000);
    // jog cycle, then its stop delay with stopping raised
    jog    <= 1'b1;
    enable <= 1'b1;
    status(3'd4, 32'h0000_0FB4);
    jog <= 1'b0;
    status(3'd4, 32'h0000_0FF4);
    status(3'd1, 32'h0000_0981);
    // remote run from the control register
    bus(1'b1, `DSQ_OFF_CTRL, 32'h0000_005D);
    status(3'd4, 32'h0000_0F94);
    // configuration restore forces start disabled, run is then ignored
    cfg_restore <= 1'b1;
    @(posedge core_clk_in);
    cfg_restore <= 1'b0;
    status(3'd0, 32'h0000_0880);
    // reset in start disabled with the contactor closed and run still commanded
    reset_n_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    reset_n_in <= 1'b1;
    @(posedge core_clk_in);
    @(negedge core_clk_in);
    check("code after mid reset", {29'h0, code}, 32'h0000_0000);
    check("contactor after mid reset", {31'h0, contactor}, 32'h0000_0000);
    check("irq after mid reset", {31'h0, irq}, 32'h0000_0000);
    status(3'd1, 32'h0000_0901);
    end_of_test();
  end
endmodule
